// >>> rtl/isrc_readout.sv
// Purpose: Row and column readout, column track/hold and serial configuration of the sensor.
// Assumes: All control pins are asynchronous to i_mclk and pass two flip-flops first.
// Notes: Edges of the slow sensor clocks are found by sampling them on i_mclk.
// Functional notes
// - Column level is tracked while the strobe is active and held when it ends.
// - Word is 32 bits: row start 1-10, column start 14-23, DAC 25-31.
// - Row scan runs bottom to top when bit 0 is one, else top to bottom.
// - Column scan runs left to right when bit 13 is zero, else reversed.
// - All-zero word starts readout at row zero, column zero.
// - Bit 11 enables averaging, bit 12 subsampling, bit 24 selects two outputs.
// - DAC field zero gives the lowest DAC level.
// - Column sync initialises the column address; column step clock sets pixel rate.
// - Line end status rises when the column scan reaches the end of the line.
// - One frame end status per row scan direction, set at frame end.
// - Configuration check output shows the bit leaving the serial shift chain.
// - Serial data shifts on its own clock; a separate load copies the word.
// - Converter is linear when select is one, gamma corrected when zero.
// - Converter result bits are inverted when invert input is one.
// - Converter gives a 10-bit result, bit 9 MSB, on its own clock.
// - Actual start address is twice the loaded row or column field.
// - Row step rising edge selects next row; row sync reinitialises the row address.
// - One output gives two pixels per column period: first high, second low.
// - Control inputs are active high unless noted; unused inputs tied inactive.
`timescale 1ns/10ps
module isrc_readout (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_cfg_clock,
   input wire logic i_cfg_data,
   input wire logic i_cfg_load,
   input wire logic i_sync_x,
   input wire logic i_clock_x,
   input wire logic i_sync_y,
   input wire logic i_clock_y,
   input wire logic i_row_deselect,
   input wire logic i_col_precharge,
   input wire logic i_column_track_hold_strobe_n,
   input wire logic i_col_average,
   input wire logic i_bus_precharge_a,
   input wire logic i_bus_precharge_b,
   input wire logic [isrc_pkg::CONV_W-1:0] i_col_level,
   input wire logic [isrc_pkg::CONV_W-1:0] i_col_level_neighbour,
   input wire logic i_converter_clock_a,
   input wire logic i_converter_linear_select_a,
   input wire logic i_converter_invert_bits_a,
   input wire logic [isrc_pkg::CONV_W-1:0] i_converter_sample_a,
   input wire logic i_converter_clock_b,
   input wire logic i_converter_linear_select_b,
   input wire logic i_converter_invert_bits_b,
   input wire logic [isrc_pkg::CONV_W-1:0] i_converter_sample_b,
   output logic [isrc_pkg::ADDR_W-1:0] o_row_addr,
   output logic [isrc_pkg::ADDR_W-1:0] o_pixel_addr_a,
   output logic [isrc_pkg::ADDR_W-1:0] o_pixel_addr_b,
   output logic o_pixel_valid,
   output logic o_line_end,
   output logic o_frame_end_down,
   output logic o_frame_end_up,
   output logic o_cfg_check,
   output logic [isrc_pkg::CONV_W-1:0] o_col_held,
   output logic o_bus_precharged,
   output logic o_avg_enable,
   output logic o_subsample,
   output logic o_two_outputs,
   output logic [isrc_pkg::DAC_W-1:0] o_dac_level,
   output logic [isrc_pkg::CONV_W-1:0] o_converter_result_a,
   output logic [isrc_pkg::CONV_W-1:0] o_converter_result_b
);

   typedef struct packed {
      isrc_pkg::isrc_pins_t meta;
      isrc_pkg::isrc_pins_t sync;
      isrc_pkg::isrc_pins_t prev;
      logic [isrc_pkg::CFG_W-1:0] shift;
      isrc_pkg::isrc_cfg_t cfg;
      logic [isrc_pkg::ADDR_W-1:0] row;
      logic [isrc_pkg::ADDR_W-1:0] col;
      logic col_active;
      logic [isrc_pkg::ADDR_W-1:0] pix_a;
      logic [isrc_pkg::ADDR_W-1:0] pix_b;
      logic line_end;
      logic frame_end_down;
      logic frame_end_up;
      logic [isrc_pkg::CONV_W-1:0] held;
      logic bus_precharged;
   } isrc_state_t;

   isrc_state_t s_r;
   isrc_state_t s_nxt;
   isrc_pkg::isrc_pins_t pins;
   logic [isrc_pkg::CONV_W:0] avg_sum;
   logic [isrc_pkg::ADDR_W-1:0] col_step;
   logic [isrc_pkg::ADDR_W-1:0] row_start;
   logic [isrc_pkg::ADDR_W-1:0] col_start;
   logic [isrc_pkg::ADDR_W-1:0] pair_first;
   logic [isrc_pkg::ADDR_W-1:0] pair_second;
   logic [isrc_pkg::ADDR_W-1:0] col_end;
   logic clk_x_rise;
   logic clk_y_rise;

   always_comb begin
      pins.cfg_clock = i_cfg_clock;
      pins.cfg_data = i_cfg_data;
      pins.cfg_load = i_cfg_load;
      pins.sync_x = i_sync_x;
      pins.clock_x = i_clock_x;
      pins.sync_y = i_sync_y;
      pins.clock_y = i_clock_y;
      pins.row_deselect = i_row_deselect;
      pins.col_precharge = i_col_precharge;
      pins.col_track_hold_n = i_column_track_hold_strobe_n;
      pins.col_average = i_col_average;
      pins.bus_precharge_a = i_bus_precharge_a;
      pins.bus_precharge_b = i_bus_precharge_b;
      pins.conv_clock_a = i_converter_clock_a;
      pins.conv_linear_a = i_converter_linear_select_a;
      pins.conv_invert_a = i_converter_invert_bits_a;
      pins.conv_clock_b = i_converter_clock_b;
      pins.conv_linear_b = i_converter_linear_select_b;
      pins.conv_invert_b = i_converter_invert_bits_b;
   end

   always_comb begin
      row_start = {s_r.cfg.row_start, 1'h0};
      col_start = {s_r.cfg.col_start, 1'h0};
      col_step = s_r.cfg.subsample ? isrc_pkg::STEP_SUBSAMPLE : isrc_pkg::STEP_PAIR;
      col_end = s_r.cfg.col_reverse ? isrc_pkg::ADDR_FIRST : isrc_pkg::PAIR_LAST;
      clk_x_rise = s_r.sync.clock_x && !s_r.prev.clock_x;
      clk_y_rise = s_r.sync.clock_y && !s_r.prev.clock_y;
      avg_sum = {1'h0, s_r.held} + {1'h0, i_col_level_neighbour};
      // Reverse scan presents the upper pixel of each pair first.
      pair_first = s_r.cfg.col_reverse ? s_r.col + isrc_pkg::STEP_ONE : s_r.col;
      pair_second = s_r.cfg.col_reverse ? s_r.col : s_r.col + isrc_pkg::STEP_ONE;
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.meta = pins;
      s_nxt.sync = s_r.meta;
      s_nxt.prev = s_r.sync;

      // Serial configuration chain, first bit lands in bit 31.
      if (s_r.sync.cfg_clock && !s_r.prev.cfg_clock) begin
         s_nxt.shift = {s_r.shift[isrc_pkg::CFG_W-2:0], s_r.sync.cfg_data};
      end
      if (s_r.sync.cfg_load && !s_r.prev.cfg_load) begin
         s_nxt.cfg = isrc_pkg::isrc_cfg_t'(s_r.shift);
      end

      // Row addressing: sync dominates every step edge.
      if (s_r.sync.sync_y) begin
         s_nxt.row = row_start;
         s_nxt.frame_end_down = 1'h0;
         s_nxt.frame_end_up = 1'h0;
      end else if (clk_y_rise) begin
         if (s_r.cfg.row_bottom_up) begin
            if (s_r.row == isrc_pkg::ADDR_FIRST) begin
               s_nxt.frame_end_up = 1'h1;
            end else begin
               s_nxt.row = s_r.row - isrc_pkg::STEP_ONE;
            end
         end else begin
            if (s_r.row == isrc_pkg::ADDR_LAST) begin
               s_nxt.frame_end_down = 1'h1;
            end else begin
               s_nxt.row = s_r.row + isrc_pkg::STEP_ONE;
            end
         end
      end

      // Column addressing: a new row stops the line until the next column sync.
      if (s_r.sync.sync_x) begin
         s_nxt.col = col_start;
         s_nxt.line_end = 1'h0;
         s_nxt.col_active = clk_x_rise ? 1'h1 : s_r.col_active;
      end else if (clk_y_rise) begin
         s_nxt.col_active = 1'h0;
      end else if (clk_x_rise && s_r.col_active && !s_r.line_end) begin
         if (s_r.col == col_end || (s_r.cfg.col_reverse && s_r.col < col_step)
             || (!s_r.cfg.col_reverse && s_r.col > isrc_pkg::PAIR_LAST - col_step)) begin
            s_nxt.line_end = 1'h1;
         end else if (s_r.cfg.col_reverse) begin
            s_nxt.col = s_r.col - col_step;
         end else begin
            s_nxt.col = s_r.col + col_step;
         end
      end

      // Pixel selection: both pixels of the pair at once with two outputs, else per column clock phase.
      if (s_r.cfg.two_outputs) begin
         s_nxt.pix_a = pair_first;
         s_nxt.pix_b = pair_second;
      end else begin
         s_nxt.pix_a = s_r.sync.clock_x ? pair_first : pair_second;
         s_nxt.pix_b = isrc_pkg::ADDR_FIRST;
      end

      // Column track/hold: strobe is active low; held value freezes on its release.
      if (s_r.sync.col_precharge || s_r.sync.row_deselect) begin
         s_nxt.held = isrc_pkg::COL_PRECHARGE_LEVEL;
      end else if (!s_r.sync.col_track_hold_n) begin
         s_nxt.held = i_col_level;
      end else if (s_r.cfg.avg_enable && s_r.sync.col_average && !s_r.prev.col_average) begin
         s_nxt.held = avg_sum[isrc_pkg::CONV_W:1];
      end

      // A bus precharge pulse shorter than one clock period can fall between samples.
      s_nxt.bus_precharged = s_r.sync.bus_precharge_a && s_r.sync.bus_precharge_b;
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         s_r <= '0;
         s_r.cfg <= isrc_pkg::isrc_cfg_t'(isrc_pkg::CFG_RESET);
      end else begin
         s_r <= s_nxt;
      end
   end

   isrc_converter u_conv_a (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_converter_clock(s_r.sync.conv_clock_a),
      .i_converter_linear_select(s_r.sync.conv_linear_a),
      .i_converter_invert_bits(s_r.sync.conv_invert_a),
      .i_sample(i_converter_sample_a),
      .o_result(o_converter_result_a)
   );

   isrc_converter u_conv_b (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_converter_clock(s_r.sync.conv_clock_b),
      .i_converter_linear_select(s_r.sync.conv_linear_b),
      .i_converter_invert_bits(s_r.sync.conv_invert_b),
      .i_sample(i_converter_sample_b),
      .o_result(o_converter_result_b)
   );

   assign o_row_addr = s_r.row;
   assign o_pixel_addr_a = s_r.pix_a;
   assign o_pixel_addr_b = s_r.pix_b;
   assign o_pixel_valid = s_r.col_active;
   assign o_line_end = s_r.line_end;
   assign o_frame_end_down = s_r.frame_end_down;
   assign o_frame_end_up = s_r.frame_end_up;
   assign o_cfg_check = s_r.shift[isrc_pkg::CFG_W-1];
   assign o_col_held = s_r.held;
   assign o_bus_precharged = s_r.bus_precharged;
   assign o_avg_enable = s_r.cfg.avg_enable;
   assign o_subsample = s_r.cfg.subsample;
   assign o_two_outputs = s_r.cfg.two_outputs;
   assign o_dac_level = s_r.cfg.dac_level;

endmodule : isrc_readout

// >>> rtl/isrc_pkg.sv
// Purpose: Shared constants and types of the image sensor readout and configuration block.
// Assumes: One 100 MHz system clock; every sensor control pin arrives asynchronously.
// Notes: The configuration word layout follows the serial shift order into the word.
package isrc_pkg;

   localparam int ADDR_W = 11;
   localparam int FIELD_W = 10;
   localparam int DAC_W = 7;
   localparam int CONV_W = 10;
   localparam int CFG_W = 32;

   localparam logic [CFG_W-1:0] CFG_RESET = 32'h0000_0000;
   localparam logic [ADDR_W-1:0] ADDR_FIRST = 11'h000;
   localparam logic [ADDR_W-1:0] ADDR_LAST = 11'h7FF;
   localparam logic [ADDR_W-1:0] PAIR_LAST = 11'h7FE;
   localparam logic [ADDR_W-1:0] STEP_ONE = 11'h001;
   localparam logic [ADDR_W-1:0] STEP_PAIR = 11'h002;
   localparam logic [ADDR_W-1:0] STEP_SUBSAMPLE = 11'h004;
   localparam logic [CONV_W-1:0] BUS_PRECHARGE_LEVEL = 10'h000;
   localparam logic [CONV_W-1:0] COL_PRECHARGE_LEVEL = 10'h000;

   // Gamma curve knee and segment offsets.
   localparam logic [CONV_W-1:0] GAMMA_KNEE = 10'h080;
   localparam logic [CONV_W-1:0] GAMMA_BASE = 10'h200;
   localparam int GAMMA_LOW_SHIFT = 2;
   localparam int GAMMA_HIGH_SHIFT_A = 1;
   localparam int GAMMA_HIGH_SHIFT_B = 4;

   // Readout timing figures that the controller keeps, kept here for reference by the bench.
   localparam int CLK_PERIOD_NS = 10;
   localparam int STD_SETTLE_NS = 180;
   localparam int STD_SETTLE_CYC = (STD_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TH_MIN_NS = 100;
   localparam int TH_MAX_NS = 200;
   localparam int TH_MIN_CYC = (TH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TH_MAX_CYC = TH_MAX_NS / CLK_PERIOD_NS;

   // Configuration word, bit 31 first down to bit 0.
   typedef struct packed {
      logic [DAC_W-1:0] dac_level;
      logic two_outputs;
      logic [FIELD_W-1:0] col_start;
      logic col_reverse;
      logic subsample;
      logic avg_enable;
      logic [FIELD_W-1:0] row_start;
      logic row_bottom_up;
   } isrc_cfg_t;

   // Asynchronous control pins, synchronised as one vector.
   typedef struct packed {
      logic cfg_clock;
      logic cfg_data;
      logic cfg_load;
      logic sync_x;
      logic clock_x;
      logic sync_y;
      logic clock_y;
      logic row_deselect;
      logic col_precharge;
      logic col_track_hold_n;
      logic col_average;
      logic bus_precharge_a;
      logic bus_precharge_b;
      logic conv_clock_a;
      logic conv_linear_a;
      logic conv_invert_a;
      logic conv_clock_b;
      logic conv_linear_b;
      logic conv_invert_b;
   } isrc_pins_t;

endpackage : isrc_pkg

// >>> rtl/isrc_converter.sv
// Purpose: Output stage of one on-chip converter: curve select, bit inversion, result register.
// Assumes: Converter clock, select and invert inputs arrive already synchronised.
// Notes: The result updates one cycle after a detected converter clock rising edge.
`timescale 1ns/10ps
module isrc_converter (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_converter_clock,
   input wire logic i_converter_linear_select,
   input wire logic i_converter_invert_bits,
   input wire logic [isrc_pkg::CONV_W-1:0] i_sample,
   output logic [isrc_pkg::CONV_W-1:0] o_result
);

   typedef struct packed {
      logic clk_prev;
      logic [isrc_pkg::CONV_W-1:0] result;
   } isrc_conv_state_t;

   isrc_conv_state_t s_r;
   isrc_conv_state_t s_nxt;
   logic [isrc_pkg::CONV_W-1:0] curve;
   logic [isrc_pkg::CONV_W-1:0] above;

   // Gamma compresses highlights: steep below the knee, shallow above it.
   always_comb begin
      above = i_sample - isrc_pkg::GAMMA_KNEE;
      if (i_converter_linear_select) begin
         curve = i_sample;
      end else if (i_sample < isrc_pkg::GAMMA_KNEE) begin
         curve = i_sample << isrc_pkg::GAMMA_LOW_SHIFT;
      end else begin
         curve = isrc_pkg::GAMMA_BASE + (above >> isrc_pkg::GAMMA_HIGH_SHIFT_A)
            + (above >> isrc_pkg::GAMMA_HIGH_SHIFT_B);
      end
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.clk_prev = i_converter_clock;
      if (i_converter_clock && !s_r.clk_prev) begin
         s_nxt.result = i_converter_invert_bits ? ~curve : curve;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_result = s_r.result;

endmodule : isrc_converter

// >>> tb/isrc_ctrl_model.sv
// Purpose: Behavioural controller that loads the configuration word over the serial port.
// Assumes: A request is i_start high for one cycle while o_busy is low.
// Notes: The serial clock has a 170 ns period and stands still low outside a load.
`timescale 1ns/10ps
module isrc_ctrl_model (
   input wire logic i_mclk,
   input wire logic i_start,
   input wire logic [31:0] i_word,
   output logic o_cfg_clock,
   output logic o_cfg_data,
   output logic o_cfg_load,
   output logic o_busy
);
   initial begin
      o_cfg_clock = 1'h0;
      o_cfg_data = 1'h0;
      o_cfg_load = 1'h0;
      o_busy = 1'h0;
      forever begin
         @(posedge i_mclk iff i_start);
         o_busy = 1'h1;
         for (int i = 31; i >= 0; i--) begin
            @(negedge i_mclk) o_cfg_data = i_word[i];
            repeat (8) @(negedge i_mclk);
            o_cfg_clock = 1'h1;
            repeat (8) @(negedge i_mclk);
            o_cfg_clock = 1'h0;
         end
         // The released data line shows the inverse of its last bit.
         o_cfg_data = ~o_cfg_data;
         repeat (4) @(negedge i_mclk);
         o_cfg_load = 1'h1;
         repeat (4) @(negedge i_mclk);
         o_cfg_load = 1'h0;
         o_busy = 1'h0;
      end
   end
endmodule : isrc_ctrl_model

// >>> tb/isrc_readout_checker.sv
// Purpose: Concurrent checks on the ports of the readout block.
// Assumes: Control pins change away from the rising clock edge.
// Notes: A shadow of the serial chain is kept from the raw pins.
`timescale 1ns/10ps
module isrc_readout_checker (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_cfg_clock,
   input wire logic i_cfg_data,
   input wire logic i_cfg_load,
   input wire logic i_sync_x,
   input wire logic i_sync_y,
   input wire logic i_row_deselect,
   input wire logic i_col_precharge,
   input wire logic i_column_track_hold_strobe_n,
   input wire logic i_col_average,
   input wire logic i_bus_precharge_a,
   input wire logic i_bus_precharge_b,
   input wire logic i_converter_clock_a,
   input wire logic i_converter_linear_select_a,
   input wire logic i_converter_invert_bits_a,
   input wire logic [9:0] i_converter_sample_a,
   input wire logic [10:0] o_pixel_addr_b,
   input wire logic o_line_end,
   input wire logic o_frame_end_down,
   input wire logic o_frame_end_up,
   input wire logic o_cfg_check,
   input wire logic [9:0] o_col_held,
   input wire logic o_bus_precharged,
   input wire logic o_avg_enable,
   input wire logic o_subsample,
   input wire logic o_two_outputs,
   input wire logic [6:0] o_dac_level,
   input wire logic [9:0] o_converter_result_a
);
   logic clk_prev_r;
   logic [31:0] chain_r;
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_sys_rst);
   function automatic logic [9:0] conv_f(logic [9:0] x, logic lin, logic inv);
      logic [9:0] d;
      logic [9:0] y;
      d = x - 10'h080;
      y = lin ? x : (x < 10'h080) ? (x << 2) : 10'h200 + (d >> 1) + (d >> 4);
      return inv ? ~y : y;
   endfunction : conv_f
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         clk_prev_r <= 1'h0;
         chain_r <= 32'h0000_0000;
      end else begin
         clk_prev_r <= i_cfg_clock;
         if (i_cfg_clock && !clk_prev_r) begin
            chain_r <= {chain_r[30:0], i_cfg_data};
         end
      end
   end
   sequence s_conv_rise;
      $rose(i_converter_clock_a) ##1 ($stable(i_converter_sample_a)
         && $stable(i_converter_linear_select_a) && $stable(i_converter_invert_bits_a))[*6];
   endsequence
   a_conv_result: assert property (s_conv_rise |=>
      o_converter_result_a == conv_f(i_converter_sample_a, i_converter_linear_select_a,
      i_converter_invert_bits_a)) else $error("converter result wrong");
   a_cfg_fields: assert property ($rose(i_cfg_load) |-> ##5
      (o_dac_level == chain_r[31:25] && o_two_outputs == chain_r[24]
      && o_subsample == chain_r[12] && o_avg_enable == chain_r[11]))
      else $error("configuration fields wrong");
   a_cfg_check: assert property ($rose(i_cfg_clock) |-> ##4
      o_cfg_check == chain_r[31]) else $error("chain check bit wrong");
   a_frame_clear: assert property (i_sync_y[*5] |->
      !o_frame_end_down && !o_frame_end_up) else $error("frame flag not cleared");
   a_line_clear: assert property (i_sync_x[*5] |-> !o_line_end)
      else $error("line flag not cleared");
   a_bus_set: assert property ((i_bus_precharge_a && i_bus_precharge_b)[*5]
      |-> o_bus_precharged) else $error("bus precharge not seen");
   a_bus_clear: assert property ((!i_bus_precharge_a)[*5] |-> !o_bus_precharged)
      else $error("bus precharge without strobe");
   a_held_zero: assert property (i_col_precharge[*5] |-> o_col_held == 10'h000)
      else $error("held level not forced low");
   a_held_frozen: assert property ((i_column_track_hold_strobe_n && !i_col_precharge
      && !i_row_deselect && !i_col_average)[*6] |=> $stable(o_col_held))
      else $error("held level moved while stored");
   a_pair_b_zero: assert property ((!o_two_outputs)[*2] |-> o_pixel_addr_b == 11'h000)
      else $error("second pixel in one output mode");
endmodule : isrc_readout_checker
bind isrc_readout isrc_readout_checker chk_u (.*);

// >>> tb/testbench.sv
// Purpose: Self-checking bench of the sensor readout block.
// Assumes: The controller model loads the configuration word.
// Notes: Pins change on the falling edge of the clock.
`timescale 1ns/10ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin fails++; \
   $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module testbench;
   logic clk, rst, start, le, fd, fu, bus, avg, sub, two, cc, cd, cl, busy, pv;
   logic [31:0] word;
   isrc_pkg::isrc_pins_t p;
   logic [9:0] lvl, nb, sa, sb, held, ra, rb;
   logic [10:0] row, pa, pb;
   logic [6:0] dac;
   int fails, comparisons;
   isrc_readout dut_u (.i_mclk(clk), .i_sys_rst(rst), .i_cfg_clock(cc), .i_cfg_data(cd),
      .i_cfg_load(cl), .i_sync_x(p.sync_x), .i_clock_x(p.clock_x), .i_sync_y(p.sync_y),
      .i_clock_y(p.clock_y), .i_row_deselect(p.row_deselect), .i_col_precharge(p.col_precharge),
      .i_column_track_hold_strobe_n(p.col_track_hold_n), .i_col_average(p.col_average),
      .i_bus_precharge_a(p.bus_precharge_a), .i_bus_precharge_b(p.bus_precharge_b),
      .i_col_level(lvl), .i_col_level_neighbour(nb), .i_converter_clock_a(p.conv_clock_a),
      .i_converter_linear_select_a(p.conv_linear_a), .i_converter_invert_bits_a(p.conv_invert_a),
      .i_converter_sample_a(sa), .i_converter_clock_b(p.conv_clock_b),
      .i_converter_linear_select_b(p.conv_linear_b), .i_converter_invert_bits_b(p.conv_invert_b),
      .i_converter_sample_b(sb), .o_row_addr(row), .o_pixel_addr_a(pa), .o_pixel_addr_b(pb),
      .o_pixel_valid(pv), .o_line_end(le), .o_frame_end_down(fd), .o_frame_end_up(fu),
      .o_cfg_check(), .o_col_held(held), .o_bus_precharged(bus), .o_avg_enable(avg),
      .o_subsample(sub), .o_two_outputs(two), .o_dac_level(dac), .o_converter_result_a(ra),
      .o_converter_result_b(rb));
   isrc_ctrl_model ctl_u (.i_mclk(clk), .i_start(start), .i_word(word), .o_cfg_clock(cc),
      .o_cfg_data(cd), .o_cfg_load(cl), .o_busy(busy));
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   task automatic report_and_stop;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : report_and_stop
   task automatic step_y;
      p.clock_y = 1'h1;
      cyc(4);
      p.clock_y = 1'h0;
      cyc(4);
   endtask : step_y
   // Row sync encloses one row clock rise; the row address loads from the sync level alone.
   task automatic sync_row;
      p.sync_y = 1'h1;
      cyc(3);
      p.clock_y = 1'h1;
      cyc(3);
      p.sync_y = 1'h0;
      cyc(1);
      p.clock_y = 1'h0;
      cyc(4);
   endtask : sync_row
   task automatic sync_col;
      p.sync_x = 1'h1;
      cyc(4);
      p.clock_x = 1'h1;
      cyc(4);
      p.sync_x = 1'h0;
      cyc(4);
   endtask : sync_col
   task automatic half_x(input logic v);
      p.clock_x = v;
      cyc(8);
   endtask : half_x
   task automatic t_zero;
      `CHK("dac", 7'h00, dac)
      `CHK("two", 1'h0, two)
      sync_row;
      `CHK("row", 11'h000, row)
      step_y;
      `CHK("row", 11'h001, row)
      sync_col;
      `CHK("pa", 11'h000, pa)
      `CHK("valid", 1'h1, pv)
      `CHK("pb", 11'h000, pb)
      half_x(1'h0);
      `CHK("pa", 11'h001, pa)
      half_x(1'h1);
      `CHK("pa", 11'h002, pa)
      half_x(1'h0);
      $display("zero scan done");
   endtask : t_zero
   task automatic t_config;
      int k;
      word = {7'h55, 1'h1, 10'h006, 1'h1, 1'h1, 1'h1, 10'h005, 1'h1};
      start = 1'h1;
      cyc(1);
      start = 1'h0;
      k = 0;
      while (busy !== 1'h0 && k < 1000) begin
         cyc(1);
         k++;
      end
      if (k >= 1000) begin
         fails++;
         report_and_stop;
      end
      cyc(6);
      `CHK("dac", 7'h55, dac)
      `CHK("flags", 3'h7, {two, sub, avg})
      sync_row;
      `CHK("row", 11'h00A, row)
      step_y;
      `CHK("row", 11'h009, row)
      sync_col;
      `CHK("pair", {11'h00D, 11'h00C}, {pa, pb})
      half_x(1'h0);
      for (k = 1; k <= 4; k++) begin
         half_x(1'h1);
         `CHK("line", k == 4, le)
         if (k < 4) `CHK("pa", 11'(13 - 4 * k), pa)
         half_x(1'h0);
      end
      for (k = 1; k <= 10; k++) begin
         step_y;
         `CHK("frame", k == 10, fu)
      end
      `CHK("row", 11'h000, row)
      `CHK("down", 1'h0, fd)
      `CHK("valid", 1'h0, pv)
      $display("config scan done");
   endtask : t_config
   task automatic t_track;
      lvl = 10'h2AB;
      p.col_precharge = 1'h1;
      p.row_deselect = 1'h1;
      cyc(6);
      `CHK("held", 10'h000, held)
      p.col_precharge = 1'h0;
      p.row_deselect = 1'h0;
      cyc(9);
      `CHK("held", 10'h2AB, held)
      p.col_track_hold_n = 1'h1;
      cyc(5);
      lvl = 10'h155;
      cyc(5);
      `CHK("held", 10'h2AB, held)
      nb = 10'h0AB;
      p.col_average = 1'h1;
      cyc(4);
      p.col_average = 1'h0;
      cyc(6);
      `CHK("avg", 10'h1AB, held)
      p.bus_precharge_a = 1'h1;
      p.bus_precharge_b = 1'h1;
      cyc(6);
      `CHK("bus", 1'h1, bus)
      p.bus_precharge_b = 1'h0;
      cyc(5);
      `CHK("bus", 1'h0, bus)
      p.bus_precharge_a = 1'h0;
      cyc(6);
      $display("track hold done");
   endtask : t_track
   task automatic t_conv;
      logic [21:0] tv [4];
      tv = '{{1'h1, 1'h0, 10'h3A5, 10'h3A5}, {1'h0, 1'h0, 10'h010, 10'h040},
         {1'h0, 1'h1, 10'h100, 10'h1B7}, {1'h1, 1'h1, 10'h0F0, 10'h30F}};
      for (int i = 0; i < 4; i++) begin
         {p.conv_linear_a, p.conv_invert_a, sa} = tv[i][21:10];
         {p.conv_linear_b, p.conv_invert_b, sb} = tv[i][21:10];
         cyc(2);
         p.conv_clock_a = 1'h1;
         p.conv_clock_b = 1'h1;
         cyc(7);
         `CHK("res_a", tv[i][9:0], ra)
         `CHK("res_b", tv[i][9:0], rb)
         p.conv_clock_a = 1'h0;
         p.conv_clock_b = 1'h0;
         cyc(4);
      end
      $display("converter done");
   endtask : t_conv
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   initial begin
      rst = 1'h1;
      start = 1'h0;
      word = 32'h0000_0000;
      p = '0;
      lvl = 10'h000;
      nb = 10'h000;
      sa = 10'h000;
      sb = 10'h000;
      fails = 0;
      comparisons = 0;
      cyc(12);
      rst = 1'h0;
      cyc(4);
      t_zero;
      t_config;
      t_track;
      t_conv;
      report_and_stop;
   end
endmodule : testbench
